// ===== idc_params.svh
/*
 * Constants of the indexed IRQ, DMA and IR configuration bank: indices,
 * reset values, field positions, write masks, codes and timing.
 * Assumes it is included by its bare name wherever the names are needed.
 */
`ifndef IDC_PARAMS_SVH
`define IDC_PARAMS_SVH

// ====================================================================
// Register indices
`define IDC_IDX_IRQ1 8'h29
`define IDC_IDX_IRQ2 8'h2A
`define IDC_IDX_BASE 8'h2B
`define IDC_IDX_DMA 8'h2C
`define IDC_IDX_TAT 8'h2D
`define IDC_IDX_SWSEL 8'h2E
`define IDC_IDX_RST 8'h00

// ====================================================================
// Reset values and writable bits
`define IDC_IRQ1_RST 8'h80
`define IDC_IRQ2_RST 8'h00
`define IDC_BASE_RST 8'h00
`define IDC_DMA_RST 8'h00
`define IDC_TAT_RST 8'h03
`define IDC_SWSEL_RST 8'h00
`define IDC_IRQ1_WMASK 8'h9F
`define IDC_NIB_WMASK 8'h0F

// ====================================================================
// Field positions
`define IDC_B_RXSEL 4
`define IDC_B_SIRQ 7
`define IDC_B_RSVD 5
`define IDC_MAP_MSB 3
`define IDC_BASE_HI_MSB 7
`define IDC_BASE_HI_LSB 5
`define IDC_ADDR_TOP_MSB 15
`define IDC_ADDR_TOP_LSB 11
`define IDC_ADDR_MID_MSB 10
`define IDC_ADDR_MID_LSB 3

// ====================================================================
// Codes
`define IDC_IRQ_NONE 4'h0
`define IDC_DMA_CH1 4'h1
`define IDC_DMA_CH3 4'h3
`define IDC_DMA_NONE 4'hF

// ====================================================================
// Timing: one timeout unit is 100 us, the clock period 5 ns
`define IDC_TAT_UNIT_NS 100000
`define IDC_CLK_PERIOD_NS 5
`define IDC_TAT_TICK_CYC (`IDC_TAT_UNIT_NS / `IDC_CLK_PERIOD_NS)

`endif

// ===== idc_pkg.sv
/*
 * Types shared by the configuration bank and its surroundings.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package idc_pkg;

    // ================================================================
    // Host access through the index and data ports.
    typedef struct packed {
        logic idx_wr;
        logic data_wr;
        logic data_rd;
        logic [7:0] wdata;
    } idc_cfg_req_t;

    // ================================================================
    // Accesses from the infrared engine to its mirrored registers.
    typedef struct packed {
        logic tat_wr;
        logic swsel_wr;
        logic soft_rst;
        logic [7:0] wdata;
    } idc_eng_req_t;

    // ================================================================
    // I/O cycle seen by the address decoder.
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } idc_io_req_t;

    // Turnaround timer phases.
    typedef enum logic [0:0] {
        IDC_TAT_IDLE,
        IDC_TAT_RUN
    } idc_tat_st_t;

endpackage

// ===== idc_config_bank.sv
/*
 * Indexed configuration bank: IRQ mapping of two external interrupt pins,
 * infrared receive source, serial IRQ enable, fast-infrared base decode,
 * DMA channel select, mirrored turnaround timeout and software select.
 * Assumes synchronous inputs on clk_sys, a configuration-state level from
 * the surrounding controller, and an engine that writes its mirrors here.
 */
`timescale 1ns/1ps
`include "idc_params.svh"

// Summary of operation
// (RL1) Bank registers 29H-2EH reachable only in config state via loaded index.
// (RL2) Low nibble of first mapping register routes interrupt input one.
// (RL3) Interrupt lines selected by no mapping field stay released.
// (RL4) Bit 4 picks receive source: 0 mode pin, 1 third receive pin.
// (RL5) Bit 5 is reserved: writes ignored, reads zero.
// (RL6) Bit 7 enables serial IRQ and clock run; reset value 0x80.
// (RL7) Second mapping nibble routes input two; upper nibble reads zero.
// (RL8) Base register holds address bits 10 to 3.
// (RL9) Base bits 10 to 8 all zero disables the engine decode.
// (RL10) Decode needs address 15:11 zero and 10:3 equal base; 2:0 ignored.
// (RL11) DMA nibble codes 1 to 3 select channels, 15 none; upper zero.
// (RL12) DMA request outputs not selected stay released.
// (RL13) Turnaround delay is value times 100 us; reset value 0x03.
// (RL14) Timeout mirror shared with engine; either write updates both.
// (RL15) Engine software reset leaves timeout mirror unchanged.
// (RL16) Software select register is one storage shared with the engine.
// (RL17) Code 0 means no interrupt; software must not share one line.
// (RL18) Accesses outside configuration state change nothing.
module idc_config_bank #(
    parameter int TICK_CYC = `IDC_TAT_TICK_CYC
) (
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // Host configuration access
    input wire logic cfg_state,
    input wire idc_pkg::idc_cfg_req_t cfg_req,
    output logic [7:0] cfg_rdata_q,
    output logic cfg_rvalid_q,
    // Interrupt routing
    input wire logic external_irq_input_one,
    input wire logic external_irq_input_two,
    output logic [15:0] irq_out_q,
    output logic [15:0] irq_oe_b_q,
    output logic serial_irq_clock_run_enable_q,
    // Infrared receive path
    input wire logic ir_mode_pin,
    input wire logic third_ir_receive_pin,
    output logic ir_rx_q,
    // Fast-infrared engine decode and DMA
    input wire idc_pkg::idc_io_req_t io_req,
    output logic fir_sel_q,
    input wire logic fir_drq,
    output logic [3:1] drq_out_q,
    output logic [3:1] drq_oe_b_q,
    // Engine mirrors and turnaround timer
    input wire idc_pkg::idc_eng_req_t eng_req,
    output logic [7:0] tat_value_q,
    output logic [7:0] swsel_value_q,
    input wire logic tat_start,
    output logic tat_busy_q
);
    import idc_pkg::*;

    // ================================================================
    // Elaboration checks
    localparam int SUB_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(TICK_CYC - 1);

    if (TICK_CYC < 1) begin : g_bad_tick
        $error("TICK_CYC must be at least one cycle");
    end

    // ================================================================
    // Helpers
    // Turns a four-bit interrupt code into a one-hot line mask; code 0 gives an all-zero mask.
    function automatic logic [15:0] irq_mask(input logic [3:0] code);
        logic [15:0] m;
        m = 16'h0000;
        if (code != `IDC_IRQ_NONE) begin
            m[code] = 1'b1;
        end
        return m;
    endfunction

    // True when the DMA code names one of the three channels.
    function automatic logic dma_valid(input logic [3:0] code);
        return (code >= `IDC_DMA_CH1) && (code <= `IDC_DMA_CH3);
    endfunction

    // ================================================================
    // Storage
    logic [7:0] idx_q;
    logic [7:0] irq1_q;
    logic [7:0] irq2_q;
    logic [7:0] base_q;
    logic [7:0] dma_q;
    logic [SUB_W-1:0] sub_q;
    logic [7:0] units_q;
    idc_tat_st_t tat_st_q;
    logic host_wr;
    logic host_rd;
    logic [15:0] sel_mask;
    logic base_on;
    logic addr_hit;

    // Host strobes count only inside configuration state.
    assign host_wr = ce && cfg_state && cfg_req.data_wr; // RL18
    assign host_rd = ce && cfg_state && cfg_req.data_rd; // RL1
    assign sel_mask = irq_mask(irq1_q[`IDC_MAP_MSB:0]) | irq_mask(irq2_q[`IDC_MAP_MSB:0]);
    assign base_on = base_q[`IDC_BASE_HI_MSB:`IDC_BASE_HI_LSB] != 3'h0; // RL9
    assign addr_hit = io_req.valid
        && (io_req.addr[`IDC_ADDR_TOP_MSB:`IDC_ADDR_TOP_LSB] == 5'h00)
        && (io_req.addr[`IDC_ADDR_MID_MSB:`IDC_ADDR_MID_LSB] == base_q); // RL10

    // ================================================================
    // Index register
    // Loaded by the host only while the controller is in configuration state.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            idx_q <= `IDC_IDX_RST;
        end else if (ce && cfg_state && cfg_req.idx_wr) begin
            idx_q <= cfg_req.wdata; // RL1
        end
    end

    // Interrupt and mode register; reserved bits never store a one.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq1_q <= `IDC_IRQ1_RST; // RL6
        end else if (host_wr && idx_q == `IDC_IDX_IRQ1) begin
            irq1_q <= cfg_req.wdata & `IDC_IRQ1_WMASK; // RL5
        end
    end

    // Second interrupt mapping; only the low nibble is writable.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq2_q <= `IDC_IRQ2_RST;
        end else if (host_wr && idx_q == `IDC_IDX_IRQ2) begin
            irq2_q <= cfg_req.wdata & `IDC_NIB_WMASK; // RL7
        end
    end

    // Engine base address, bits 10 to 3 of the I/O address.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            base_q <= `IDC_BASE_RST;
        end else if (host_wr && idx_q == `IDC_IDX_BASE) begin
            base_q <= cfg_req.wdata; // RL8
        end
    end

    // DMA channel select; only the low nibble is writable.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dma_q <= `IDC_DMA_RST;
        end else if (host_wr && idx_q == `IDC_IDX_DMA) begin
            dma_q <= cfg_req.wdata & `IDC_NIB_WMASK; // RL11
        end
    end

    // Timeout mirror: host write wins over a same-cycle engine write, and
    // the engine software reset is deliberately not looked at here.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tat_value_q <= `IDC_TAT_RST; // RL13
        end else if (host_wr && idx_q == `IDC_IDX_TAT) begin
            tat_value_q <= cfg_req.wdata; // RL14
        end else if (ce && eng_req.tat_wr) begin
            tat_value_q <= eng_req.wdata; // RL14 RL15
        end
    end

    // Software select storage shared by the host and the engine.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            swsel_value_q <= `IDC_SWSEL_RST;
        end else if (host_wr && idx_q == `IDC_IDX_SWSEL) begin
            swsel_value_q <= cfg_req.wdata; // RL16
        end else if (ce && eng_req.swsel_wr) begin
            swsel_value_q <= eng_req.wdata; // RL16
        end
    end

    // ================================================================
    // Read port
    // Indices outside this bank give no valid strobe and keep the data.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cfg_rdata_q <= 8'h00;
            cfg_rvalid_q <= 1'b0;
        end else if (ce) begin
            cfg_rvalid_q <= 1'b0;
            if (host_rd) begin
                cfg_rvalid_q <= 1'b1;
                if (idx_q == `IDC_IDX_IRQ1) begin
                    cfg_rdata_q <= irq1_q;
                end else if (idx_q == `IDC_IDX_IRQ2) begin
                    cfg_rdata_q <= irq2_q;
                end else if (idx_q == `IDC_IDX_BASE) begin
                    cfg_rdata_q <= base_q;
                end else if (idx_q == `IDC_IDX_DMA) begin
                    cfg_rdata_q <= dma_q;
                end else if (idx_q == `IDC_IDX_TAT) begin
                    cfg_rdata_q <= tat_value_q;
                end else if (idx_q == `IDC_IDX_SWSEL) begin
                    cfg_rdata_q <= swsel_value_q;
                end else begin
                    cfg_rvalid_q <= 1'b0;
                end
            end
        end
    end

    // ================================================================
    // Interrupt routing
    // Each selected line carries its pin; unselected lines are released.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_out_q <= 16'h0000;
            irq_oe_b_q <= 16'hFFFF;
        end else if (ce) begin
            irq_out_q <= ({16{external_irq_input_one}} & irq_mask(irq1_q[`IDC_MAP_MSB:0]))
                | ({16{external_irq_input_two}} & irq_mask(irq2_q[`IDC_MAP_MSB:0])); // RL2 RL7
            irq_oe_b_q <= ~sel_mask; // RL3 RL17
        end
    end

    // Serial IRQ enable and receive source follow the mode register.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            serial_irq_clock_run_enable_q <= 1'b1;
            ir_rx_q <= 1'b0;
        end else if (ce) begin
            serial_irq_clock_run_enable_q <= irq1_q[`IDC_B_SIRQ]; // RL6
            ir_rx_q <= irq1_q[`IDC_B_RXSEL] ? third_ir_receive_pin : ir_mode_pin; // RL4
        end
    end

    // ================================================================
    // Engine decode and DMA steering
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            fir_sel_q <= 1'b0;
        end else if (ce) begin
            fir_sel_q <= base_on && addr_hit; // RL9 RL10
        end
    end

    // Only a valid channel code drives a request line.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            drq_out_q <= 3'h0;
            drq_oe_b_q <= 3'h7;
        end else if (ce) begin
            drq_out_q <= 3'h0;
            drq_oe_b_q <= 3'h7; // RL12
            if (dma_valid(dma_q[`IDC_MAP_MSB:0])) begin
                drq_out_q[dma_q[1:0]] <= fir_drq; // RL11
                drq_oe_b_q[dma_q[1:0]] <= 1'b0;
            end
        end
    end

    // ================================================================
    // Turnaround timer
    // Counts the stored value in 100 us units; a zero value never starts.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tat_st_q <= IDC_TAT_IDLE;
            units_q <= 8'h00;
            sub_q <= '0;
            tat_busy_q <= 1'b0;
        end else if (ce) begin
            case (tat_st_q)
                IDC_TAT_IDLE: begin
                    if (tat_start && tat_value_q != 8'h00) begin
                        tat_st_q <= IDC_TAT_RUN; // RL13
                        units_q <= tat_value_q;
                        sub_q <= SUB_LAST;
                        tat_busy_q <= 1'b1;
                    end
                end
                IDC_TAT_RUN: begin
                    if (sub_q != '0) begin
                        sub_q <= sub_q - 1'b1;
                    end else if (units_q == 8'h01) begin
                        tat_st_q <= IDC_TAT_IDLE;
                        units_q <= 8'h00;
                        tat_busy_q <= 1'b0;
                    end else begin
                        units_q <= units_q - 8'h01;
                        sub_q <= SUB_LAST;
                    end
                end
                default: begin
                    tat_st_q <= IDC_TAT_IDLE;
                end
            endcase
        end
    end

    // ================================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    AST_CFG_GATE: assert property ( // RL18
        (ce && !cfg_state) |=> ($stable(irq1_q) && $stable(base_q) && $stable(dma_q)))
        else $error("bank changed outside configuration state");
    AST_RSVD_BITS: assert property ( // RL5
        (irq1_q[`IDC_B_RSVD] == 1'b0) && (irq1_q[6] == 1'b0))
        else $error("reserved mode bit set");
    AST_HIGH_NIBBLES: assert property ( // RL7
        (irq2_q[7:4] == 4'h0) && (dma_q[7:4] == 4'h0))
        else $error("read-only nibble set");
    AST_IRQ_RELEASE: assert property ( // RL3
        ce |=> (irq_oe_b_q == ~$past(sel_mask)))
        else $error("interrupt enable does not match mapping");
    AST_IRQ_ONE_ROUTE: assert property ( // RL2
        (ce && irq1_q[3:0] != 4'h0 && irq2_q[3:0] != irq1_q[3:0])
        |=> (irq_out_q[$past(irq1_q[3:0])] == $past(external_irq_input_one)))
        else $error("input one not routed");
    AST_BASE_OFF: assert property ( // RL9
        (ce && base_q[7:5] == 3'h0) |=> !fir_sel_q)
        else $error("engine decoded while disabled");
    AST_DECODE: assert property ( // RL10
        (ce && io_req.valid && base_q[7:5] != 3'h0
            && io_req.addr[15:11] == 5'h00 && io_req.addr[10:3] == base_q)
        |=> fir_sel_q)
        else $error("engine address not decoded");
    AST_DMA_RELEASE: assert property ( // RL12
        (ce && !dma_valid(dma_q[3:0])) |=> (drq_oe_b_q == 3'h7))
        else $error("unselected request line driven");
    AST_RX_SOURCE: assert property ( // RL4
        ce |=> (ir_rx_q == ($past(irq1_q[4]) ? $past(third_ir_receive_pin)
            : $past(ir_mode_pin))))
        else $error("wrong receive source");
    AST_SIRQ_EN: assert property ( // RL6
        ce |=> (serial_irq_clock_run_enable_q == $past(irq1_q[7])))
        else $error("serial irq enable mismatch");
    AST_MIRROR: assert property ( // RL14
        (ce && eng_req.tat_wr && !(host_wr && idx_q == `IDC_IDX_TAT))
        |=> (tat_value_q == $past(eng_req.wdata)))
        else $error("engine timeout write lost");
    AST_SOFT_RST: assert property ( // RL15
        (ce && eng_req.soft_rst && !eng_req.tat_wr && !host_wr) |=> $stable(tat_value_q))
        else $error("soft reset changed timeout");
    AST_SWSEL: assert property ( // RL16
        (ce && eng_req.swsel_wr && !(host_wr && idx_q == `IDC_IDX_SWSEL))
        |=> (swsel_value_q == $past(eng_req.wdata)))
        else $error("shared select write lost");

    COV_TAT_RUN: cover property (tat_start && ce && tat_value_q != 8'h00 ##1 tat_busy_q);
    COV_DECODE: cover property (fir_sel_q);
    COV_DMA_DRIVE: cover property (drq_oe_b_q != 3'h7);
    COV_READ: cover property (cfg_rvalid_q);
endmodule

// ===== tb.sv
/*
 * Self-checking testbench for the indexed IRQ, DMA and IR configuration bank.
 * Assumes idc_pkg is compiled first and idc_params.svh is on the include path.
 */
`timescale 1ns/1ps
`include "idc_params.svh"

module tb;
    import idc_pkg::*;

    // ================================================================
    // Stimulus and observed signals
    logic clk_sys, rst_b, ce, cfg_state;
    idc_cfg_req_t cfg_req;
    logic [7:0] cfg_rdata_q;
    logic cfg_rvalid_q, external_irq_input_one, external_irq_input_two;
    logic [15:0] irq_out_q, irq_oe_b_q;
    logic serial_irq_clock_run_enable_q, ir_mode_pin, third_ir_receive_pin, ir_rx_q;
    idc_io_req_t io_req;
    logic fir_sel_q, fir_drq;
    logic [3:1] drq_out_q, drq_oe_b_q;
    idc_eng_req_t eng_req;
    logic [7:0] tat_value_q, swsel_value_q;
    logic tat_start, tat_busy_q;
    logic [2:0] exp_oe;
    int failures, samples_checked, n;

    // A short tick keeps the turnaround delay within a few cycles.
    idc_config_bank #(.TICK_CYC(2)) idc_config_bank_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .cfg_state(cfg_state),
        .cfg_req(cfg_req), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
        .external_irq_input_one(external_irq_input_one),
        .external_irq_input_two(external_irq_input_two),
        .irq_out_q(irq_out_q), .irq_oe_b_q(irq_oe_b_q),
        .serial_irq_clock_run_enable_q(serial_irq_clock_run_enable_q),
        .ir_mode_pin(ir_mode_pin), .third_ir_receive_pin(third_ir_receive_pin),
        .ir_rx_q(ir_rx_q), .io_req(io_req), .fir_sel_q(fir_sel_q), .fir_drq(fir_drq),
        .drq_out_q(drq_out_q), .drq_oe_b_q(drq_oe_b_q), .eng_req(eng_req),
        .tat_value_q(tat_value_q), .swsel_value_q(swsel_value_q),
        .tat_start(tat_start), .tat_busy_q(tat_busy_q)
    );

    // ================================================================
    // Clock of 5 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Compares one value and counts the result.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    // Loads the index, then writes the data port on the next cycle.
    task automatic cfg_write(input logic [7:0] idx, input logic [7:0] val);
        cfg_req.idx_wr = 1'b1;
        cfg_req.wdata = idx;
        @(negedge clk_sys);
        cfg_req.idx_wr = 1'b0;
        cfg_req.data_wr = 1'b1;
        cfg_req.wdata = val;
        @(negedge clk_sys);
        cfg_req.data_wr = 1'b0;
    endtask

    // Loads the index and reads; a hit must answer, a miss must stay silent.
    task automatic cfg_read(input logic [7:0] idx, input logic [7:0] exp, input logic hit);
        cfg_req.idx_wr = 1'b1;
        cfg_req.wdata = idx;
        @(negedge clk_sys);
        cfg_req.idx_wr = 1'b0;
        cfg_req.data_rd = 1'b1;
        @(negedge clk_sys);
        cfg_req.data_rd = 1'b0;
        n = 0;
        while (cfg_rvalid_q !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        if (!hit) begin
            check("rvalid wait", 16'(n), 16'h0004);
        end else if (n == 4) begin
            check("rvalid wait", 16'(n), 16'h0000);
            give_verdict();
        end else begin
            check("rdata", 16'(cfg_rdata_q), 16'(exp));
        end
    endtask

    // Presents one I/O cycle and checks the registered select.
    task automatic probe(input logic v, input logic [15:0] a, input logic exp);
        io_req.valid = v;
        io_req.addr = a;
        @(negedge clk_sys);
        check("fir select", 16'(fir_sel_q), 16'(exp));
        // Let an idle edge pass so the next probe raises valid in a new step.
        io_req.valid = 1'b0;
        @(negedge clk_sys);
    endtask

    // Engine-side write of one mirror.
    task automatic eng_write(input logic to_tat, input logic [7:0] v);
        eng_req.tat_wr = to_tat;
        eng_req.swsel_wr = !to_tat;
        eng_req.wdata = v;
        @(negedge clk_sys);
        eng_req.tat_wr = 1'b0;
        eng_req.swsel_wr = 1'b0;
        cycles(1);
    endtask

    // ================================================================
    // Main sequence.
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        cfg_state = 1'b1;
        cfg_req = '0;
        external_irq_input_one = 1'b1;
        external_irq_input_two = 1'b0;
        ir_mode_pin = 1'b1;
        third_ir_receive_pin = 1'b0;
        io_req = '0;
        fir_drq = 1'b1;
        eng_req = '0;
        tat_start = 1'b0;
        failures = 0;
        samples_checked = 0;
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        // Reset state of outputs and registers.
        check("sirq en", 16'(serial_irq_clock_run_enable_q), 16'h0001);
        check("irq oe", irq_oe_b_q, 16'hFFFF);
        check("drq oe", 16'(drq_oe_b_q), 16'h0007);
        check("tat value", 16'(tat_value_q), 16'h0003);
        cfg_read(8'h29, 8'h80, 1'b1);
        cfg_read(8'h2A, 8'h00, 1'b1);
        cfg_read(8'h2B, 8'h00, 1'b1);
        cfg_read(8'h2D, 8'h03, 1'b1);
        // After reset the receive path follows the mode pin, which is held high.
        check("rx source", 16'(ir_rx_q), 16'h0001);
        // Interrupt mapping, reserved bits and the released lines.
        cfg_write(8'h29, 8'hE5);
        cfg_read(8'h29, 8'h85, 1'b1);
        cfg_write(8'h2A, 8'hFC);
        cfg_read(8'h2A, 8'h0C, 1'b1);
        check("irq oe map", irq_oe_b_q, 16'hEFDF);
        check("irq lines", irq_out_q & 16'h1020, 16'h0020);
        external_irq_input_one = 1'b0;
        external_irq_input_two = 1'b1;
        cycles(2);
        check("irq lines", irq_out_q & 16'h1020, 16'h1000);
        cfg_write(8'h29, 8'h10);
        cycles(2);
        check("irq oe none", irq_oe_b_q, 16'hEFFF);
        check("sirq off", 16'(serial_irq_clock_run_enable_q), 16'h0000);
        check("rx third", 16'(ir_rx_q), 16'h0000);
        third_ir_receive_pin = 1'b1;
        cycles(2);
        check("rx third", 16'(ir_rx_q), 16'h0001);
        // Fast-infrared address decode.
        cfg_write(8'h2B, 8'h21);
        cycles(1);
        probe(1'b1, 16'h010F, 1'b1);
        probe(1'b1, 16'h0108, 1'b1);
        probe(1'b0, 16'h0108, 1'b0);
        probe(1'b1, 16'h0110, 1'b0);
        probe(1'b1, 16'h0908, 1'b0);
        probe(1'b1, 16'h8108, 1'b0);
        cfg_write(8'h2B, 8'hFF);
        cycles(1);
        probe(1'b1, 16'h07F8, 1'b1);
        cfg_write(8'h2B, 8'h1F);
        cycles(1);
        probe(1'b1, 16'h00F8, 1'b0);
        // Every DMA code, with the request driven high.
        for (int c = 0; c < 16; c++) begin
            cfg_write(8'h2C, {4'hA, c[3:0]});
            cfg_read(8'h2C, {4'h0, c[3:0]}, 1'b1);
            cycles(1);
            exp_oe = (c >= 1 && c <= 3) ? 3'(~(3'b001 << (c - 1))) : 3'b111;
            check("drq oe", 16'(drq_oe_b_q), 16'(exp_oe));
            check("drq out", {13'h0000, drq_out_q}, {13'h0000, ~exp_oe});
        end
        // Mirrored timeout and shared software select.
        eng_write(1'b1, 8'h55);
        check("tat mirror", 16'(tat_value_q), 16'h0055);
        cfg_read(8'h2D, 8'h55, 1'b1);
        eng_req.soft_rst = 1'b1;
        cycles(1);
        eng_req.soft_rst = 1'b0;
        cfg_read(8'h2D, 8'h55, 1'b1);
        cfg_write(8'h2D, 8'h02);
        cycles(1);
        check("tat mirror", 16'(tat_value_q), 16'h0002);
        eng_write(1'b0, 8'hA5);
        cfg_read(8'h2E, 8'hA5, 1'b1);
        cfg_write(8'h2E, 8'h3C);
        cycles(1);
        check("swsel", 16'(swsel_value_q), 16'h003C);
        // Turnaround delay of two units of two cycles, then value zero.
        tat_start = 1'b1;
        @(negedge clk_sys);
        tat_start = 1'b0;
        n = 0;
        while (tat_busy_q === 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        check("busy cycles", 16'(n), 16'd4);
        if (n == 50) begin
            give_verdict();
        end
        cfg_write(8'h2D, 8'h00);
        tat_start = 1'b1;
        @(negedge clk_sys);
        tat_start = 1'b0;
        cycles(1);
        check("busy zero", 16'(tat_busy_q), 16'h0000);
        // Accesses outside configuration state or while frozen change nothing.
        cfg_write(8'h2D, 8'h11);
        cfg_state = 1'b0;
        cfg_write(8'h2D, 8'h77);
        cfg_state = 1'b1;
        cfg_read(8'h2D, 8'h11, 1'b1);
        ce = 1'b0;
        cfg_write(8'h2D, 8'h66);
        ce = 1'b1;
        cfg_read(8'h2D, 8'h11, 1'b1);
        // Indices just outside the bank give no answer.
        cfg_read(8'h28, 8'h00, 1'b0);
        cfg_read(8'h2F, 8'h00, 1'b0);
        give_verdict();
    end
endmodule
